//--- controller_status_report.sv
// Status bytes that the device presents to the polling host.
// Assumes a frame checker on the same clock pulses I_FRAME_DONE once per
// received frame; supply and memory-check flags come from pins.
//
// Functional notes
// - Firmware version byte is read-only, full 0..255 range.
// - Hardware version byte: tens digit major, units digit minor.
// - Variant byte holds one ASCII character naming the board variant.
// - State bit 0 set once ready and one good transfer completed.
// - Safe state clears run bit and blocks communication until restart.
// - State bits 4..7 hold fault code; zero none, one unused.
// - Payload CRC failure reports fault code 0010.
// - Header CRC failure reports fault code 0101.
// - Short data block reports fault code 0011.
// - Host variant byte unequal to own variant reports code 0100.
// - Serial clock too fast reports fault code 0110.
// - Warning bit 1 set while retained memory check fails.
// - Warning bit 2 set on low supply; retained memory not enabled.
// - Link uses serial mode 0: clock idles low, leading-edge sampling.
`timescale 1ns/10ps
module controller_status_report
    import status_report_pkg::*;
#(
    parameter logic [7:0] FIRMWARE_VERSION = 8'h01,
    parameter logic [7:0] HARDWARE_VERSION = 8'h0a,
    // Arbitrary value; real boards set their own variant character
    parameter logic [7:0] VARIANT_CHAR     = 8'h58
) (
    input  wire logic       I_CORE_CLK,
    input  wire logic       I_RESETN,
    input  wire logic       I_READY,
    input  wire logic       I_FRAME_DONE,
    input  wire logic       I_HEADER_CRC_BAD,
    input  wire logic       I_PAYLOAD_CRC_BAD,
    input  wire logic       I_FRAME_SHORT,
    input  wire logic       I_LINK_TOO_FAST,
    input  wire logic [7:0] I_VARIANT_EXPECTED,
    input  wire logic       I_SAFE_STATE,
    input  wire logic       I_STORE_CHECK_FAULT,
    input  wire logic       I_STORE_SUPPLY_LOW,
    input  wire logic       I_STORE_ENABLE_REQ,
    input  wire logic [2:0] I_READ_INDEX,
    output logic      [7:0] O_READ_DATA,
    output logic      [7:0] O_FIRMWARE_VERSION,
    output logic      [7:0] O_HARDWARE_VERSION,
    output logic      [7:0] O_BOARD_VARIANT_REPORT,
    output logic      [7:0] O_CONTROLLER_STATE,
    output logic      [7:0] O_CONTROLLER_WARNINGS,
    output logic            O_LINK_ENABLE,
    output logic            O_STORE_ENABLE
);
    import status_report_pkg::*;

    // One-hot control state; only a reset leaves st_safe
    typedef enum logic [2:0] {
        st_idle = 3'h1,
        st_run  = 3'h2,
        st_safe = 3'h4
    } ctrl_state_t;

    ctrl_state_t          ctrl_r, ctrl_nxt;
    logic                 run_nxt, safe_nxt;
    logic [FAULT_W-1:0]   frame_code;
    logic [FAULT_W-1:0]   fault_r, fault_nxt;
    logic [BYTE_W-1:0]    state_r, state_nxt;
    logic [BYTE_W-1:0]    warn_r, warn_nxt;
    logic [BYTE_W-1:0]    rdata_r, rdata_nxt;
    logic                 store_en_r, store_en_nxt;
    logic                 check_lvl, supply_lvl;

    // Memory check and supply monitor are asynchronous to the core clock
    status_pin_sync u_check_sync (
        .i_clk    (I_CORE_CLK),
        .i_resetn (I_RESETN),
        .i_pin    (I_STORE_CHECK_FAULT),
        .o_level  (check_lvl)
    );

    status_pin_sync u_supply_sync (
        .i_clk    (I_CORE_CLK),
        .i_resetn (I_RESETN),
        .i_pin    (I_STORE_SUPPLY_LOW),
        .o_level  (supply_lvl)
    );

    // Header fault outranks payload checks: a bad header makes the rest
    // of the frame meaningless.
    function automatic logic [FAULT_W-1:0] classify(
        input logic       hdr_bad,
        input logic       pay_bad,
        input logic       short_blk,
        input logic       fast,
        input logic [7:0] expected
    );
        logic [FAULT_W-1:0] code;
        code = FAULT_NONE;
        if (fast) begin
            code = FAULT_LINK_SPEED;
        end else if (hdr_bad) begin
            code = FAULT_HEADER_CRC;
        end else if (short_blk) begin
            code = FAULT_SHORT_FRAME;
        end else if (pay_bad) begin
            code = FAULT_PAYLOAD_CRC;
        end else if (expected != VARIANT_CHAR) begin
            code = FAULT_VARIANT;
        end
        return code;
    endfunction

    // Verdict on the frame that the frame checker flags this cycle
    always_comb begin
        frame_code = classify(I_HEADER_CRC_BAD, I_PAYLOAD_CRC_BAD,
                              I_FRAME_SHORT, I_LINK_TOO_FAST,
                              I_VARIANT_EXPECTED);
    end

    always_comb begin
        ctrl_nxt = ctrl_r;
        case (ctrl_r)
            st_idle: begin
                if (I_SAFE_STATE) begin
                    ctrl_nxt = st_safe;
                end else if (I_FRAME_DONE && I_READY &&
                             (frame_code == FAULT_NONE)) begin
                    ctrl_nxt = st_run;
                end
            end
            st_run: begin
                if (I_SAFE_STATE) begin
                    ctrl_nxt = st_safe;
                end else if (!I_READY) begin
                    // Firmware not ready: run flag drops at once
                    ctrl_nxt = st_idle;
                end
            end
            st_safe: begin
                // Sticky so a watchdog trip cannot be talked away
                ctrl_nxt = st_safe;
            end
            default: begin
                ctrl_nxt = st_idle;
            end
        endcase
        run_nxt  = (ctrl_nxt == st_run);
        safe_nxt = (ctrl_nxt == st_safe);
    end

    // Fault code tracks the latest frame; frames after safe are ignored
    always_comb begin
        fault_nxt = fault_r;
        if (I_FRAME_DONE && !safe_nxt) begin
            fault_nxt = frame_code;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ctrl_r  <= st_idle;
            fault_r <= FAULT_NONE;
        end else begin
            ctrl_r  <= ctrl_nxt;
            fault_r <= fault_nxt;
        end
    end

    // Bytes rebuilt from scratch each cycle so spare bits stay zero
    always_comb begin
        state_nxt = STATE_RESET;
        state_nxt[STATE_RUN_BIT] = run_nxt;
        state_nxt[STATE_FAULT_LSB +: FAULT_W] = fault_nxt;
        warn_nxt = WARN_RESET;
        warn_nxt[WARN_CHECK_BIT]  = check_lvl;
        warn_nxt[WARN_SUPPLY_BIT] = supply_lvl;
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            state_r <= STATE_RESET;
            warn_r  <= WARN_RESET;
        end else begin
            state_r <= state_nxt;
            warn_r  <= warn_nxt;
        end
    end

    // Retained memory held off while supply is low
    always_comb begin
        store_en_nxt = I_STORE_ENABLE_REQ & ~supply_lvl;
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            store_en_r <= 1'b0;
        end else begin
            store_en_r <= store_en_nxt;
        end
    end

    // Read path costs one cycle; unused indices read zero
    always_comb begin
        case (I_READ_INDEX)
            IDX_FIRMWARE: rdata_nxt = FIRMWARE_VERSION;
            IDX_HARDWARE: rdata_nxt = HARDWARE_VERSION;
            IDX_VARIANT:  rdata_nxt = VARIANT_CHAR;
            IDX_STATE:    rdata_nxt = state_r;
            IDX_WARNINGS: rdata_nxt = warn_r;
            default:      rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign O_READ_DATA            = rdata_r;
    assign O_FIRMWARE_VERSION     = FIRMWARE_VERSION;
    assign O_HARDWARE_VERSION     = HARDWARE_VERSION;
    assign O_BOARD_VARIANT_REPORT = VARIANT_CHAR;
    assign O_CONTROLLER_STATE     = state_r;
    assign O_CONTROLLER_WARNINGS  = warn_r;
    // Mode-0 serial engine sits outside; it stops answering when low
    assign O_LINK_ENABLE          = (ctrl_r != st_safe);
    assign O_STORE_ENABLE         = store_en_r;
endmodule

//--- controller_status_report_chk.sv
// Assertions on the status report block's ports.
// Bound into the block; one clock domain, reset active low.
`timescale 1ns/10ps
module controller_status_report_chk (
    input wire logic       I_CORE_CLK,
    input wire logic       I_RESETN,
    input wire logic       I_READY,
    input wire logic       I_FRAME_DONE,
    input wire logic       I_HEADER_CRC_BAD,
    input wire logic       I_PAYLOAD_CRC_BAD,
    input wire logic       I_FRAME_SHORT,
    input wire logic       I_LINK_TOO_FAST,
    input wire logic [7:0] I_VARIANT_EXPECTED,
    input wire logic       I_SAFE_STATE,
    input wire logic       I_STORE_SUPPLY_LOW,
    input wire logic [7:0] O_BOARD_VARIANT_REPORT,
    input wire logic [7:0] O_CONTROLLER_STATE,
    input wire logic [7:0] O_CONTROLLER_WARNINGS,
    input wire logic       O_LINK_ENABLE,
    input wire logic       O_STORE_ENABLE
);
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RESETN);
    // Frames after safe state are ignored, so gate on link enable
    wire tk = I_FRAME_DONE && !I_SAFE_STATE && O_LINK_ENABLE;
    wire [3:0] f = {I_LINK_TOO_FAST, I_HEADER_CRC_BAD, I_FRAME_SHORT,
                    I_PAYLOAD_CRC_BAD};
    wire vm = I_VARIANT_EXPECTED == O_BOARD_VARIANT_REPORT;
    wire [3:0] code = O_CONTROLLER_STATE[7:4];
    a_fast_code: assert property (tk && f[3] |=> code == 4'h6)
        else $error("fast link code wrong");
    a_header_code: assert property (
        tk && f[3:2] == 2'h1 |=> code == 4'h5)
        else $error("header crc code wrong");
    a_short_code: assert property (
        tk && f[3:1] == 3'h1 |=> code == 4'h3)
        else $error("short frame code wrong");
    a_payload_code: assert property (tk && f == 4'h1 |=> code == 4'h2)
        else $error("payload crc code wrong");
    a_variant_code: assert property (
        tk && f == 4'h0 && !vm |=> code == 4'h4)
        else $error("variant code wrong");
    a_clean_run: assert property (tk && f == 4'h0 && vm && I_READY
        |=> O_CONTROLLER_STATE == 8'h01)
        else $error("clean frame state wrong");
    a_safe_quiet: assert property (I_SAFE_STATE
        |=> (!O_LINK_ENABLE && !O_CONTROLLER_STATE[0]) [*4])
        else $error("safe state not quiet");
    a_supply_gate: assert property (I_STORE_SUPPLY_LOW [*7]
        |-> ##1 (O_CONTROLLER_WARNINGS[2] && !O_STORE_ENABLE))
        else $error("low supply not flagged");
    c_fault: cover property (tk && f != 4'h0);
    c_safe: cover property (I_SAFE_STATE);
    c_low: cover property (O_CONTROLLER_WARNINGS[2]);
endmodule
bind controller_status_report controller_status_report_chk chk (.*);

//--- controller_status_report_test.sv
// Self-checking bench for the status report block.
// Inputs change on falling edges; frames come from the host model.
`timescale 1ns/10ps
module controller_status_report_test;
    localparam logic [7:0] FW = 8'hff, HW = 8'h0c, VC = 8'h4b;
    logic I_CORE_CLK = 0, I_RESETN = 0, I_READY = 1, I_SAFE_STATE = 0;
    logic I_STORE_CHECK_FAULT = 0, I_STORE_SUPPLY_LOW = 0;
    logic I_STORE_ENABLE_REQ = 1;
    logic [2:0] I_READ_INDEX = 3'h0;
    logic I_FRAME_DONE, I_HEADER_CRC_BAD, I_PAYLOAD_CRC_BAD, I_FRAME_SHORT;
    logic I_LINK_TOO_FAST, O_LINK_ENABLE, O_STORE_ENABLE;
    logic [7:0] I_VARIANT_EXPECTED, O_READ_DATA, O_FIRMWARE_VERSION;
    logic [7:0] O_HARDWARE_VERSION, O_BOARD_VARIANT_REPORT;
    logic [7:0] O_CONTROLLER_STATE, O_CONTROLLER_WARNINGS;
    wire  [7:0] st = O_CONTROLLER_STATE;
    int failures = 0, total_checks = 0;
    always #5 I_CORE_CLK = ~I_CORE_CLK;
    controller_status_report #(.FIRMWARE_VERSION(FW),
        .HARDWARE_VERSION(HW), .VARIANT_CHAR(VC)) uut (.*);
    host_frame_model #(.GAP(2)) host (.i_clk(I_CORE_CLK),
        .o_done(I_FRAME_DONE), .o_hdr(I_HEADER_CRC_BAD),
        .o_pay(I_PAYLOAD_CRC_BAD), .o_short(I_FRAME_SHORT),
        .o_fast(I_LINK_TOO_FAST), .o_variant(I_VARIANT_EXPECTED));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic ticks(input int n);
        repeat (n) @(negedge I_CORE_CLK);
    endtask
    task automatic read_bytes;
        logic [7:0] e [6];
        e = '{FW, HW, VC, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++) begin
            I_READ_INDEX = 3'(i);
            ticks(1);
            check(O_READ_DATA, e[i]);
        end
        check(O_FIRMWARE_VERSION, FW);
        check(O_HARDWARE_VERSION, HW);
        check(O_BOARD_VARIANT_REPORT, VC);
    endtask
    // Fault first, before any clean frame: run must stay low
    task automatic fault_codes;
        logic [3:0] fl [7];
        logic [7:0] v [7];
        logic [7:0] e [7];
        fl = '{4'h4, 4'h0, 4'h6, 4'ha, 4'h9, 4'h0, 4'h0};
        v = '{VC, VC, VC, VC, VC, 8'h4c, VC};
        e = '{8'h20, 8'h01, 8'h31, 8'h51, 8'h61, 8'h41, 8'h01};
        for (int i = 0; i < 7; i++) begin
            host.send(fl[i], v[i]);
            check(st, e[i]);
        end
    endtask
    task automatic store_pins;
        I_STORE_SUPPLY_LOW = 1'b1;
        I_STORE_CHECK_FAULT = 1'b1;
        ticks(8);
        check(O_CONTROLLER_WARNINGS, 8'h06);
        check({7'h0, O_STORE_ENABLE}, 8'h00);
        I_STORE_SUPPLY_LOW = 1'b0;
        I_STORE_CHECK_FAULT = 1'b0;
        ticks(8);
        check(O_CONTROLLER_WARNINGS, 8'h00);
        check({7'h0, O_STORE_ENABLE}, 8'h01);
        I_STORE_ENABLE_REQ = 1'b0;
        ticks(2);
        check({7'h0, O_STORE_ENABLE}, 8'h00);
        I_STORE_ENABLE_REQ = 1'b1;
    endtask
    task automatic run_and_safe;
        I_READY = 1'b0;
        ticks(2);
        check(st, 8'h00);
        I_READY = 1'b1;
        host.send(4'h0, VC);
        check(st, 8'h01);
        I_SAFE_STATE = 1'b1;
        ticks(1);
        I_SAFE_STATE = 1'b0;
        host.send(4'h4, VC);
        check(st, 8'h00);
        check({7'h0, O_LINK_ENABLE}, 8'h00);
        // Restart must leave the safe state and allow a new run
        I_RESETN = 1'b0;
        ticks(2);
        I_RESETN = 1'b1;
        check({7'h0, O_LINK_ENABLE}, 8'h01);
        host.send(4'h0, VC);
        check(st, 8'h01);
    endtask
    initial begin
        ticks(20);
        I_RESETN = 1'b1;
        read_bytes();
        fault_codes();
        store_pins();
        run_and_safe();
        tally_and_finish();
    end
    // Hang guard; running out counts as a mismatch
    initial begin
        repeat (5000) @(posedge I_CORE_CLK);
        failures++;
        tally_and_finish();
    end
endmodule

//--- host_frame_model.sv
// Polling host, reduced to one verdict strobe per received frame.
// Drives on falling edges; flags are qualified by done alone.
`timescale 1ns/10ps
module host_frame_model #(
    parameter int GAP = 2
) (
    input  wire logic       i_clk,
    output logic            o_done,
    output logic            o_hdr,
    output logic            o_pay,
    output logic            o_short,
    output logic            o_fast,
    output logic      [7:0] o_variant
);
    initial begin
        o_done = 1'b0;
        {o_hdr, o_pay, o_short, o_fast, o_variant} = 12'h000;
    end
    // Outside a frame the flags hold junk, never the last value
    task automatic send(input logic [3:0] fl, input logic [7:0] v);
        repeat (GAP) @(negedge i_clk);
        {o_hdr, o_pay, o_short, o_fast} = fl;
        o_variant = v;
        o_done = 1'b1;
        @(negedge i_clk);
        o_done = 1'b0;
        {o_hdr, o_pay, o_short, o_fast} = ~fl;
        o_variant = ~v;
    endtask
endmodule

//--- status_pin_sync.sv
// Three-stage synchroniser for asynchronous level inputs.
// A change counts only when the second and third stages agree.
`timescale 1ns/10ps
module status_pin_sync (
    input  wire logic i_clk,
    input  wire logic i_resetn,
    input  wire logic i_pin,
    output logic      o_level
);
    logic s1_r, s2_r, s3_r, lvl_r;
    logic lvl_nxt;

    always_comb begin
        lvl_nxt = lvl_r;
        if (s2_r == s3_r) begin
            lvl_nxt = s3_r;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s1_r  <= 1'b0;
            s2_r  <= 1'b0;
            s3_r  <= 1'b0;
            lvl_r <= 1'b0;
        end else begin
            s1_r  <= i_pin;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            lvl_r <= lvl_nxt;
        end
    end

    assign o_level = lvl_r;
endmodule

//--- status_report_pkg.sv
// Constants shared by the controller status report block.
// Assumes one core clock; byte indices are positions in the outgoing frame.
package status_report_pkg;
    localparam int          BYTE_W              = 8;
    localparam int          FAULT_W             = 4;
    // Byte positions of the status bytes in the outgoing frame
    localparam logic [2:0]  IDX_FIRMWARE        = 3'h0;
    localparam logic [2:0]  IDX_HARDWARE        = 3'h1;
    localparam logic [2:0]  IDX_VARIANT         = 3'h2;
    localparam logic [2:0]  IDX_STATE           = 3'h3;
    localparam logic [2:0]  IDX_WARNINGS        = 3'h4;
    // Field positions
    localparam int          STATE_RUN_BIT       = 0;
    localparam int          STATE_FAULT_LSB     = 4;
    localparam int          WARN_CHECK_BIT      = 1;
    localparam int          WARN_SUPPLY_BIT     = 2;
    // Reset values
    localparam logic [7:0]  STATE_RESET         = 8'h00;
    localparam logic [7:0]  WARN_RESET          = 8'h00;
    // Fault codes
    localparam logic [3:0]  FAULT_NONE          = 4'h0;
    localparam logic [3:0]  FAULT_PAYLOAD_CRC   = 4'h2;
    localparam logic [3:0]  FAULT_SHORT_FRAME   = 4'h3;
    localparam logic [3:0]  FAULT_VARIANT       = 4'h4;
    localparam logic [3:0]  FAULT_HEADER_CRC    = 4'h5;
    localparam logic [3:0]  FAULT_LINK_SPEED    = 4'h6;
    // Pin synchroniser depth
    localparam int          SYNC_STAGES         = 3;
endpackage
